// *** hdl/mii_rs_pkg.sv ***
// constants and types shared by the mii reconciliation block
package mii_rs_pkg;

    // ------------------------------------------------------------
    // link geometry
    // ------------------------------------------------------------
    localparam int NIB_W = 4;
    localparam int BITS_PER_NIB = 4;
    localparam int SYNC_W = 10;

    // ------------------------------------------------------------
    // reaction bounds, in bit times
    // ------------------------------------------------------------
    localparam int START_MAX_BITS = 4;
    localparam int DETECT_MAX_BITS = 8;
    localparam int CRS_TO_TX_MAX_BITS = 16;
    localparam int COL_TO_JAM_MAX_BITS = 16;

    // bounds as whole link clock cycles (round down; the start bound at least one)
    localparam int START_MAX_CYC = (START_MAX_BITS / BITS_PER_NIB < 1) ? 1 :
        START_MAX_BITS / BITS_PER_NIB;
    localparam int COL_TO_JAM_CYC = COL_TO_JAM_MAX_BITS / BITS_PER_NIB;
    localparam int CRS_TO_TX_CYC = CRS_TO_TX_MAX_BITS / BITS_PER_NIB;

    // ------------------------------------------------------------
    // jam pattern and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] JAM_NIB = 4'h5;
    localparam int JAM_NIBBLES = 8;
    localparam logic [3:0] TXD_RST = 4'h0;

    // transmit sequencer
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_DATA,
        TX_JAM
    } tx_state_t;

endpackage

// *** hdl/mii_sync.sv ***
// two-flop synchroniser bank for the asynchronous mii inputs
module mii_sync #(
    parameter int WIDTH = 10
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // an empty bank cannot be built, refuse it at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("mii_sync width must be positive");
    end

    // first stage feeds only the second stage
    always_comb begin
        next_st = st;
        next_st.meta = din;
        next_st.sync = st.meta;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.sync;

endmodule // mii_sync

// *** hdl/mii_rs.sv ***
// mac-side reconciliation logic for a media independent interface
// --------------------------------------------------------------------
// --------------------------------------------------------------------
module mii_rs (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic full_duplex,
    input wire logic mac_tx_valid,
    input wire logic [3:0] mac_tx_nib,
    output logic mac_tx_ready,
    output logic mac_carrier,
    output logic mac_collision,
    output logic mac_rx_valid,
    output logic [3:0] mac_rx_nib,
    output logic mac_rx_end,
    output logic mac_rx_fcs_err,
    input wire logic tx_clk,
    output logic [3:0] txd,
    output logic tx_en,
    output logic tx_er,
    input wire logic rx_clk,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic crs,
    input wire logic col
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mii_rs_pkg::tx_state_t tx_st;
        logic [3:0] txd;
        logic tx_en;
        logic tx_er;
        logic tx_ready;
        logic [3:0] jam_cnt;
        logic txclk_d;
        logic rxclk_d;
        logic carrier;
        logic collision;
        logic dv_seen;
        logic rx_in_frame;
        logic rx_valid;
        logic [3:0] rx_nib;
        logic rx_end;
        logic rx_err_seen;
        logic rx_fcs_err;
        logic [2:0] start_wait;
    } rs_state_t;

    rs_state_t st;
    rs_state_t next_st;
    logic [mii_rs_pkg::SYNC_W-1:0] pins_s;
    logic txclk_s;
    logic rxclk_s;
    logic crs_s;
    logic col_s;
    logic dv_s;
    logic er_s;
    logic [3:0] rxd_s;
    logic txclk_rise;
    logic rxclk_rise;
    logic half_col;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    // all phy pins are asynchronous to mclk, link clocks included
    mii_sync #(
        .WIDTH(mii_rs_pkg::SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .din({tx_clk, rx_clk, crs, col, rx_dv, rx_er, rxd}),
        .dout(pins_s)
    );

    assign {txclk_s, rxclk_s, crs_s, col_s, dv_s, er_s, rxd_s} = pins_s;
    // edges found on the second flop only
    assign txclk_rise = txclk_s && !st.txclk_d;
    assign rxclk_rise = rxclk_s && !st.rxclk_d;
    // collision only counts in half duplex
    assign half_col = col_s && !full_duplex;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.txclk_d = txclk_s;
        next_st.rxclk_d = rxclk_s;
        next_st.tx_ready = 1'b0;
        next_st.rx_valid = 1'b0;
        next_st.rx_end = 1'b0;

        // carrier follows crs until rx_dv falls inside a frame
        if (!crs_s) begin
            next_st.dv_seen = 1'b0;
        end else if (dv_s) begin
            next_st.dv_seen = 1'b1;
        end
        next_st.carrier = crs_s && !(st.dv_seen && !dv_s);
        next_st.collision = half_col;

        // transmit: change outputs just after a link rising edge, so the
        // phy samples them stably one edge later
        if (txclk_rise) begin
            case (st.tx_st)
                mii_rs_pkg::TX_IDLE: begin
                    if (mac_tx_valid) begin
                        next_st.tx_st = mii_rs_pkg::TX_DATA;
                        next_st.tx_en = 1'b1;
                        next_st.txd = mac_tx_nib;
                        next_st.tx_ready = 1'b1;
                    end
                end
                mii_rs_pkg::TX_DATA: begin
                    if (half_col) begin
                        next_st.tx_st = mii_rs_pkg::TX_JAM;
                        next_st.txd = mii_rs_pkg::JAM_NIB;
                        next_st.jam_cnt = 4'h0;
                    end else if (mac_tx_valid) begin
                        next_st.txd = mac_tx_nib;
                        next_st.tx_ready = 1'b1;
                    end else begin
                        next_st.tx_st = mii_rs_pkg::TX_IDLE;
                        next_st.tx_en = 1'b0;
                        next_st.txd = mii_rs_pkg::TXD_RST;
                    end
                end
                mii_rs_pkg::TX_JAM: begin
                    if (st.jam_cnt == 4'(mii_rs_pkg::JAM_NIBBLES - 1)) begin
                        next_st.tx_st = mii_rs_pkg::TX_IDLE;
                        next_st.tx_en = 1'b0;
                        next_st.txd = mii_rs_pkg::TXD_RST;
                    end else begin
                        next_st.jam_cnt = st.jam_cnt + 4'h1;
                    end
                end
                default: begin
                    next_st.tx_st = mii_rs_pkg::TX_IDLE;
                    next_st.tx_en = 1'b0;
                end
            endcase
        end

        // link edges waited for a pending start, checked below
        if (st.tx_st != mii_rs_pkg::TX_IDLE || !mac_tx_valid) begin
            next_st.start_wait = 3'h0;
        end else if (txclk_rise && st.start_wait != 3'h7) begin
            next_st.start_wait = st.start_wait + 3'h1;
        end

        // receive: one nibble per rx_clk edge while rx_dv is high
        if (rxclk_rise) begin
            if (dv_s) begin
                if (!st.rx_in_frame) begin
                    next_st.rx_fcs_err = 1'b0;
                end
                next_st.rx_in_frame = 1'b1;
                next_st.rx_valid = 1'b1;
                next_st.rx_nib = rxd_s;
                if (er_s) begin
                    next_st.rx_err_seen = 1'b1;
                end
            end else if (st.rx_in_frame) begin
                // error flag rides with the end marker, held until next frame
                next_st.rx_in_frame = 1'b0;
                next_st.rx_end = 1'b1;
                next_st.rx_fcs_err = st.rx_err_seen;
                next_st.rx_err_seen = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.tx_st <= mii_rs_pkg::TX_IDLE;
            st.txd <= mii_rs_pkg::TXD_RST;
        end else begin
            st <= next_st;
        end
    end

    // the mac never asks for deliberate corruption, so this flop stays at reset
    assign tx_er = st.tx_er;
    assign txd = st.txd;
    assign tx_en = st.tx_en;
    assign mac_tx_ready = st.tx_ready;
    assign mac_carrier = st.carrier;
    assign mac_collision = st.collision;
    assign mac_rx_valid = st.rx_valid;
    assign mac_rx_nib = st.rx_nib;
    assign mac_rx_end = st.rx_end;
    assign mac_rx_fcs_err = st.rx_fcs_err;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int DET_LIM = 4;
    localparam int CRS_TX_LIM = 40;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    property p_start;
        st.tx_st == mii_rs_pkg::TX_IDLE && mac_tx_valid && txclk_rise |=> tx_en && mac_tx_ready;
    endproperty
    a_start: assert property (p_start) else $error("tx_en not raised at link edge");

    property p_start_bound;
        st.start_wait <= 3'(mii_rs_pkg::START_MAX_CYC);
    endproperty
    a_start_bound: assert property (p_start_bound) else $error("start waited too long");

    property p_crs_detect;
        $rose(crs) && !st.dv_seen |-> ##[1:DET_LIM] mac_carrier;
    endproperty
    a_crs_detect: assert property (p_crs_detect) else $error("carrier rise missed");

    property p_crs_to_tx;
        $rose(mac_carrier) && mac_tx_valid |-> ##[1:CRS_TX_LIM] tx_en;
    endproperty
    a_crs_to_tx: assert property (p_crs_to_tx) else $error("tx start late after carrier");

    property p_col_fall;
        $fell(col) |-> ##[1:DET_LIM] !mac_collision;
    endproperty
    a_col_fall: assert property (p_col_fall) else $error("collision drop missed");

    property p_jam;
        st.tx_st == mii_rs_pkg::TX_DATA && half_col && txclk_rise
            |=> tx_en && txd == mii_rs_pkg::JAM_NIB;
    endproperty
    a_jam: assert property (p_jam) else $error("jam nibble not presented");

    property p_jam_end;
        st.tx_st == mii_rs_pkg::TX_JAM && st.jam_cnt == 4'(mii_rs_pkg::JAM_NIBBLES - 1)
            && txclk_rise |=> !tx_en;
    endproperty
    a_jam_end: assert property (p_jam_end) else $error("jam did not end");

    property p_dv_carrier;
        $fell(dv_s) && crs_s && st.dv_seen |=> !mac_carrier;
    endproperty
    a_dv_carrier: assert property (p_dv_carrier) else $error("carrier kept after rx_dv drop");

    property p_fcs_err;
        rxclk_rise && !dv_s && st.rx_in_frame && st.rx_err_seen |=> mac_rx_end && mac_rx_fcs_err;
    endproperty
    a_fcs_err: assert property (p_fcs_err) else $error("receive error not flagged");

    property p_rx_nib;
        rxclk_rise && dv_s |=> mac_rx_valid && mac_rx_nib == $past(rxd_s);
    endproperty
    a_rx_nib: assert property (p_rx_nib) else $error("receive nibble lost");

    c_jam: cover property (st.tx_st == mii_rs_pkg::TX_JAM ##1 !tx_en);
    c_frame_end: cover property (tx_en ##1 !tx_en);
    c_dv_drop: cover property (crs_s && st.dv_seen && !dv_s);
    c_fcs: cover property (mac_rx_end && mac_rx_fcs_err);

endmodule // mii_rs

// *** tb/phy_model.sv ***
// phy-side partner: link clocks, receive frames, transmit capture
module phy_model (
    output logic tx_clk,
    output logic rx_clk,
    output logic [3:0] rxd,
    output logic rx_dv,
    output logic rx_er,
    output logic crs,
    output logic col,
    input wire logic [3:0] txd,
    input wire logic tx_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] tx_q[$];
    // --------------------------------
    // link clocks
    // --------------------------------
    // both run free, phases unrelated to mclk and to each other
    // one fixed rate; its report over management is not modelled
    initial begin
        tx_clk = 1'b0;
        #13;
        forever #160 tx_clk = ~tx_clk;
    end
    initial begin
        rx_clk = 1'b0;
        {rxd, rx_dv, rx_er, crs, col} = '0;
        #71;
        forever #160 rx_clk = ~rx_clk;
    end
    // --------------------------------
    // receive and transmit paths
    // --------------------------------
    // captures each nibble that tx_en qualifies at a rising edge
    always @(posedge tx_clk) begin
        if (tx_en === 1'b1) tx_q.push_back(txd);
    end
    // data changes off the sampling edge; error only where asked
    task automatic send(input logic [3:0] nibs[$], input logic err, input logic tail);
        @(negedge rx_clk);
        crs <= 1'b1;
        foreach (nibs[i]) begin
            @(negedge rx_clk);
            rx_dv <= 1'b1;
            rxd <= nibs[i];
            rx_er <= err && (i == 0);
        end
        @(negedge rx_clk);
        rx_dv <= 1'b0;
        rx_er <= 1'b0;
        rxd <= ~rxd; // a released bundle does not keep its value
        crs <= tail;
    endtask
endmodule // phy_model

// *** tb/mii_mac_reconciliation_bench.sv ***
// self-checking bench for the mii reconciliation block
module mii_mac_reconciliation_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [3:0] nib; logic [3:0] exp;} row_t;
    logic mclk, rst_b, full_duplex, mac_tx_valid, mac_tx_ready, mac_carrier;
    logic mac_collision, mac_rx_valid, mac_rx_end, mac_rx_fcs_err;
    logic [3:0] mac_tx_nib, mac_rx_nib, txd, rxd;
    logic tx_en, tx_er, tx_clk, rx_clk, rx_dv, rx_er, crs, col;
    logic [3:0] rx_q[$], nq[$], dq[$];
    row_t rows[8] = '{8'h00, 8'hFF, 8'hAA, 8'h55, 8'h11, 8'h88, 8'hCC, 8'h33};
    int n_fail = 0, cmp_count = 0, n, jams, n_end = 0;
    time t0;
    mii_rs dut_u (
        .mclk(mclk), .rst_b(rst_b), .full_duplex(full_duplex),
        .mac_tx_valid(mac_tx_valid), .mac_tx_nib(mac_tx_nib), .mac_tx_ready(mac_tx_ready),
        .mac_carrier(mac_carrier), .mac_collision(mac_collision),
        .mac_rx_valid(mac_rx_valid), .mac_rx_nib(mac_rx_nib), .mac_rx_end(mac_rx_end),
        .mac_rx_fcs_err(mac_rx_fcs_err), .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en),
        .tx_er(tx_er), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
        .crs(crs), .col(col)
    );
    phy_model phy_u (
        .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
        .crs(crs), .col(col), .txd(txd), .tx_en(tx_en)
    );
    // --------------------------------
    // clock, watchdog, helpers
    // --------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // whole run needs well under this span
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    always @(posedge mclk) begin
        if (mac_rx_valid === 1'b1) rx_q.push_back(mac_rx_nib);
        if (mac_rx_end === 1'b1) n_end++;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    // holds each nibble until ready; gives up on collision as the mac would
    // own counter: the checking branch runs beside this task and uses n
    task automatic mac_send(input logic [3:0] nibs[$]);
        int k;
        foreach (nibs[i]) begin
            mac_tx_valid <= 1'b1;
            mac_tx_nib <= nibs[i];
            k = 0;
            do begin
                @(posedge mclk);
                k++;
            end while (mac_tx_ready !== 1'b1 && mac_collision !== 1'b1 && k < 100);
            if (mac_collision === 1'b1 || k >= 100) break;
        end
        mac_tx_valid <= 1'b0;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        {rst_b, mac_tx_valid, mac_tx_nib} = '0;
        full_duplex = 1'b1;
        // two edges in reset, so the reset values have settled when read
        @(posedge mclk);
        @(posedge mclk);
        check("reset tx", {txd, tx_en, tx_er, mac_carrier}, 8'h00);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        done("reset");
        // full duplex table, collision line raised but ignored
        foreach (rows[i]) nq.push_back(rows[i].nib);
        phy_u.col <= 1'b1;
        fork
            mac_send(nq);
            phy_u.send(nq, 1'b0, 1'b0);
        join
        repeat (20) @(posedge mclk);
        foreach (rows[i]) begin
            check("tx nib", phy_u.tx_q[i], rows[i].exp);
            check("rx nib", rx_q[i], rows[i].exp);
        end
        check("tx count", 8'(phy_u.tx_q.size()), 8'h08);
        check("fd col", mac_collision, 1'b0);
        check("no fcs", mac_rx_fcs_err, 1'b0);
        check("rx end", 8'(n_end), 8'h01);
        phy_u.col <= 1'b0;
        done("table");
        // receive error inside a frame
        phy_u.send('{4'h1, 4'h2}, 1'b1, 1'b0);
        repeat (16) @(posedge mclk);
        check("fcs err", mac_rx_fcs_err, 1'b1);
        done("rx error");
        // carrier on and off, then rx_dv drop with carrier held
        phy_u.crs <= 1'b1;
        n = 0;
        while (mac_carrier !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        check("crs on", 8'(n <= 16), 8'h01);
        phy_u.crs <= 1'b0;
        n = 0;
        while (mac_carrier !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        check("crs off", 8'(n <= 16), 8'h01);
        phy_u.send('{4'h7}, 1'b0, 1'b1);
        repeat (8) @(posedge mclk);
        check("dv drop", {crs, mac_carrier}, 8'h02);
        phy_u.crs <= 1'b0;
        done("carrier");
        // half duplex start, collision and jam
        full_duplex <= 1'b0;
        phy_u.tx_q.delete();
        repeat (16) dq.push_back(4'hA);
        @(posedge tx_clk);
        @(posedge mclk);
        // carrier rises with the start request, so the start also bounds carrier
        phy_u.crs <= 1'b1;
        fork
            mac_send(dq);
            begin
                @(posedge tx_clk);
                check("tx start", tx_en, 1'b1);
                repeat (2) @(posedge tx_clk);
                @(posedge mclk);
                phy_u.col <= 1'b1;
                t0 = $time;
                n = 0;
                while (mac_collision !== 1'b1 && n < 40) begin
                    @(posedge mclk);
                    n++;
                end
                check("col on", 8'(n <= 16), 8'h01);
                n = 0;
                while (!(tx_en === 1'b1 && txd === 4'h5) && n < 8) begin
                    @(posedge tx_clk);
                    n++;
                end
                check("jam time", 8'($time - t0 <= 1280), 8'h01);
            end
        join
        repeat (12) @(posedge tx_clk);
        jams = 0;
        foreach (phy_u.tx_q[i]) jams += (phy_u.tx_q[i] === 4'h5);
        check("jam count", 8'(jams), 8'h08);
        check("jam end", tx_en, 1'b0);
        phy_u.col <= 1'b0;
        phy_u.crs <= 1'b0;
        n = 0;
        while (mac_collision !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        check("col off", 8'(n <= 16), 8'h01);
        done("collision");
        stop_test();
    end
endmodule // mii_mac_reconciliation_bench
